// >>> verilog/qsel_defines.svh
// Purpose: offsets, field positions, reset values and sizes for the read-select block
// Assumes: sys_clk at 200 MHz
// Notes:   included by the cfg_chain and queue_read_select design modules
`ifndef QSEL_DEFINES_SVH
`define QSEL_DEFINES_SVH

`define QSEL_QUEUE_LO      0
`define QSEL_QUEUE_HI      1
`define QSEL_NULL_BIT      2
`define QSEL_DEV_LO        3
`define QSEL_DEV_HI        5
`define QSEL_NUM_QUEUES    4
`define QSEL_NUM_DEVICES   8
`define QSEL_CFG_BITS      16
`define QSEL_PAE_RESET     4'hF
`define QSEL_FIFO_DEPTH    8

`endif

// >>> verilog/qsel_pkg.sv
// Purpose: shared types for the read-select and configuration chain block
// Assumes: nothing beyond the defines header
// Notes:   types only; numbers live in the defines header
package qsel_pkg;
	typedef enum logic [2:0] {
		CFG_WAIT  = 3'b001,
		CFG_SHIFT = 3'b010,
		CFG_DONE  = 3'b100
	} cfg_state_type;

	typedef enum logic [1:0] {
		FLAG_DIRECT = 2'b01,
		FLAG_POLLED = 2'b10
	} flag_mode_type;
endpackage

// >>> verilog/word_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   read data is combinational from the head slot (fall-through)
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;

	wire doWrite = inValid && inReady;
	wire doRead  = outValid && outReady;

	assign inReady  = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem[rdPtr_q];

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (doWrite) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n || flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doWrite) begin
				wrPtr_q <= nextPtr(wrPtr_q);
			end
			if (doRead) begin
				rdPtr_q <= nextPtr(rdPtr_q);
			end
			count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end
endmodule

// >>> verilog/cfg_chain.sv
// Purpose: serial configuration shift chain with enable pass-through
// Assumes: serial clock, data and chain enable arrive as pins and are synchronised here
// Notes:   configuration bits shift in on serial-clock rising edges seen in sys_clk
`timescale 1ns/1ps
`include "qsel_defines.svh"
module cfg_chain
	import qsel_pkg::*;
#(
	parameter int CFG_BITS = `QSEL_CFG_BITS
) (
	input  wire logic                sys_clk,
	input  wire logic                reset_n,
	input  wire logic                serialMode,
	input  wire logic                serialClk,
	input  wire logic                serialIn,
	input  wire logic                chainEnableInN,
	output logic                     chainEnableOutN,
	output logic                     serialOut,
	output logic                     cfgDone,
	output logic      [CFG_BITS-1:0] cfgWord
);
	logic [2:0]          sclkSync_q;
	logic [1:0]          sdiSync_q;
	logic [1:0]          senSync_q;
	logic [CFG_BITS-1:0] shift_q;
	logic [$clog2(CFG_BITS+1)-1:0] bitCount_q;
	cfg_state_type       state_q;
	cfg_state_type       state_d;

	// only the second and third stages feed logic; the first is a pure synchroniser
	wire sclkRise = sclkSync_q[1] && !sclkSync_q[2];
	wire senLow   = !senSync_q[1];
	wire capture  = (state_q == CFG_SHIFT) && sclkRise && senLow;
	wire lastBit  = (bitCount_q == ($clog2(CFG_BITS+1))'(CFG_BITS - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			CFG_WAIT:  state_d = serialMode ? CFG_SHIFT : CFG_DONE;
			CFG_SHIFT: if (capture && lastBit) begin
				state_d = CFG_DONE;
			end
			CFG_DONE:  state_d = CFG_DONE;
			default:   state_d = CFG_WAIT;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sclkSync_q <= '0;
			sdiSync_q  <= '0;
			senSync_q  <= 2'b11;
		end else begin
			sclkSync_q <= {sclkSync_q[1:0], serialClk};
			sdiSync_q  <= {sdiSync_q[0], serialIn};
			senSync_q  <= {senSync_q[0], chainEnableInN};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q         <= CFG_WAIT;
			shift_q         <= '0;
			bitCount_q      <= '0;
			chainEnableOutN <= 1'b1;
			serialOut       <= 1'b0;
			cfgDone         <= 1'b0;
			cfgWord         <= '0;
		end else begin
			state_q <= state_d;
			if (capture) begin
				shift_q    <= {shift_q[CFG_BITS-2:0], sdiSync_q[1]};
				bitCount_q <= bitCount_q + 1'b1;
			end
			if (state_q == CFG_SHIFT && state_d == CFG_DONE) begin
				cfgWord <= {shift_q[CFG_BITS-2:0], sdiSync_q[1]};
			end
			cfgDone <= (state_q == CFG_DONE);
			// held high until done, then follows the input enable
			chainEnableOutN <= (state_q == CFG_DONE) ? senSync_q[1] : 1'b1;
			// once loaded, serial data passes straight on to the next device
			serialOut <= (state_q == CFG_DONE) ? sdiSync_q[1] : 1'b0;
		end
	end
endmodule

// >>> verilog/queue_read_select.sv
// Purpose: read-port queue selection, almost-empty status selection and config gating
// Assumes: host select, strobe and read-enable pins arrive asynchronously and pass two flip-flops; queue data arrives
//          from on-chip queue storage on sys_clk
// Notes:   the read clock of the device is sys_clk; the serial clock is sampled
`timescale 1ns/1ps
`include "qsel_defines.svh"
module queue_read_select
	import qsel_pkg::*;
#(
	parameter int WIDTH     = 18,
	parameter int NQ        = `QSEL_NUM_QUEUES,
	parameter int FIFO_DEPTH = `QSEL_FIFO_DEPTH,
	parameter int CFG_BITS  = `QSEL_CFG_BITS,
	parameter logic [2:0] DEVICE_ID = 3'h0
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset_n,
	input  wire logic [5:0]           queueSelectBus,
	input  wire logic                 queueSelectStrobe,
	input  wire logic                 flagDeviceStrobe,
	input  wire logic                 readEnableN,
	input  wire logic                 serialMode,
	input  wire logic                 polledFlagMode,
	input  wire logic                 configShiftClk,
	input  wire logic                 serialIn,
	input  wire logic                 chainEnableInput,
	output logic                      chainEnableOutput,
	output logic                      serialOut,
	input  wire logic [NQ*WIDTH-1:0]  queueData,
	input  wire logic [NQ-1:0]        queueValid,
	output logic      [NQ-1:0]        queueTake,
	input  wire logic [NQ-1:0]        queueAlmostEmptyN,
	output logic      [WIDTH-1:0]     outputWordBus,
	output logic                      outputValid,
	output logic      [NQ-1:0]        almostEmptyStatusBus,
	output logic                      almostEmptyStatusEnable,
	output logic                      configDone
);
	logic [5:0]       selSync1_q;
	logic [5:0]       selSync2_q;
	logic [2:0]       strbSync1_q;
	logic [2:0]       strbSync2_q;
	logic [2:0]       curQueue_q;
	logic             ready_q;
	logic [1:0]       changeAge_q;
	logic [2:0]       flagDev_q;
	logic [2:0]       pollDev_q;
	logic             cfgDone;
	logic             senoN;
	logic [WIDTH-1:0] fifoOutData;
	logic             fifoOutValid;
	logic             fifoInReady;

	wire [5:0] selBus  = selSync2_q;
	wire       selStrb = strbSync2_q[0];
	wire       devStrb = strbSync2_q[1];
	wire       renN    = strbSync2_q[2];

	function automatic logic isRealQueue(input logic [2:0] q);
		isRealQueue = !q[`QSEL_NULL_BIT];
	endfunction

	function automatic logic [WIDTH-1:0] queueWord(input logic [NQ*WIDTH-1:0] d, input logic [1:0] q);
		queueWord = d[q*WIDTH +: WIDTH];
	endfunction

	// normal operation starts when the chain enable output falls and then stays on,
	// so raising the chain input again later does not stop the queues
	wire ready = ready_q || (cfgDone && !senoN);
	// the host must hold off the strobe until ready; a stray early strobe is dropped
	wire takeSel  = ready && selStrb && !devStrb;
	wire takeDev  = ready && devStrb && !selStrb;
	wire matchSel = (selBus[`QSEL_DEV_HI:`QSEL_DEV_LO] == DEVICE_ID);
	wire [2:0] newQueue = matchSel ? selBus[2:0] : 3'b100;

	wire [1:0] curIdx    = curQueue_q[1:0];
	// queueTake lags the fill by a clock, so a queue just taken is skipped for one clock
	// to avoid buffering the same word twice; this halves the prefetch rate
	wire       curValid  = isRealQueue(curQueue_q) && queueValid[curIdx] && !queueTake[curIdx];
	// no prefetch inside the switch window, so no new-queue word is taken and then flushed
	wire       fillFifo  = ready && curValid && fifoInReady && (changeAge_q == 2'd0);
	// second edge after a select: the new queue's head word falls through, read enable or not
	wire       bypass    = ready && curValid && (changeAge_q == 2'd1);
	wire       flushFifo = (changeAge_q == 2'd1);
	// first edge after a select: a buffered old-queue word goes out regardless of read enable
	wire       readWord  = fifoOutValid && (!renN || (changeAge_q == 2'd2));

	word_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.flush    (flushFifo),
		.inData   (queueWord(queueData, curIdx)),
		.inValid  (fillFifo),
		.inReady  (fifoInReady),
		.outData  (fifoOutData),
		.outValid (fifoOutValid),
		.outReady (readWord)
	);

	cfg_chain #(
		.CFG_BITS (CFG_BITS)
	) u_cfg (
		.sys_clk         (sys_clk),
		.reset_n         (reset_n),
		.serialMode      (serialMode),
		.serialClk       (configShiftClk),
		.serialIn        (serialIn),
		.chainEnableInN  (chainEnableInput),
		.chainEnableOutN (senoN),
		.serialOut       (serialOut),
		.cfgDone         (cfgDone),
		.cfgWord         ()
	);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ready_q <= 1'b0;
		end else if (cfgDone && !senoN) begin
			ready_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			selSync1_q  <= '0;
			selSync2_q  <= '0;
			strbSync1_q <= 3'b100;
			strbSync2_q <= 3'b100;
		end else begin
			selSync1_q  <= queueSelectBus;
			selSync2_q  <= selSync1_q;
			strbSync1_q <= {readEnableN, flagDeviceStrobe, queueSelectStrobe};
			strbSync2_q <= strbSync1_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			curQueue_q  <= 3'b100;
			changeAge_q <= 2'd0;
		end else if (takeSel) begin
			curQueue_q  <= newQueue;
			changeAge_q <= 2'd2;
		end else if (changeAge_q != 2'd0) begin
			changeAge_q <= changeAge_q - 2'd1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			flagDev_q <= '0;
			pollDev_q <= '0;
		end else begin
			if (takeDev) begin
				flagDev_q <= selBus[`QSEL_DEV_HI:`QSEL_DEV_LO];
			end
			// polled mode steps through all devices every clock, no read enable needed
			if (ready) begin
				pollDev_q <= pollDev_q + 3'd1;
			end
		end
	end

	wire [2:0] statusDev = polledFlagMode ? pollDev_q : flagDev_q;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			outputWordBus           <= '0;
			outputValid             <= 1'b0;
			queueTake               <= '0;
			almostEmptyStatusBus    <= NQ'(`QSEL_PAE_RESET);
			almostEmptyStatusEnable <= 1'b0;
			chainEnableOutput       <= 1'b1;
			configDone              <= 1'b0;
		end else begin
			if (bypass) begin
				outputWordBus <= queueWord(queueData, curIdx);
			end else if (readWord) begin
				outputWordBus <= fifoOutData;
			end
			outputValid             <= readWord || bypass;
			queueTake               <= (fillFifo || bypass) ? (NQ'(1) << curIdx) : '0;
			// only the addressed device raises the status enable; the status bus carries queueAlmostEmptyN whenever ready
			almostEmptyStatusEnable <= ready && (statusDev == DEVICE_ID);
			almostEmptyStatusBus    <= ready ? queueAlmostEmptyN : NQ'(`QSEL_PAE_RESET);
			chainEnableOutput       <= senoN;
			configDone              <= ready;
		end
	end
endmodule

// >>> verif/queue_read_select_checker.sv
// Purpose: port-level checks for queue_read_select
// Assumes: one clock, reset_n synchronous active low
// Notes:   repeat counts leave room for the input synchronisers
`timescale 1ns/1ps
module queue_read_select_checker #(
	parameter int NQ = 4
) (
	input wire logic          sys_clk,
	input wire logic          reset_n,
	input wire logic          chainEnableInput,
	input wire logic          polledFlagMode,
	input wire logic          chainEnableOutput,
	input wire logic          configDone,
	input wire logic [NQ-1:0] queueTake,
	input wire logic [NQ-1:0] queueValid,
	input wire logic          almostEmptyStatusEnable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	property p_holdHigh; !configDone |-> chainEnableOutput; endproperty
	a_holdHigh: assert property (p_holdHigh) else $error("chain out low early");
	property p_followHigh; (configDone && chainEnableInput) [*5] |-> chainEnableOutput; endproperty
	a_followHigh: assert property (p_followHigh) else $error("chain out not high");
	property p_followLow; (configDone && !chainEnableInput) [*5] |-> !chainEnableOutput; endproperty
	a_followLow: assert property (p_followLow) else $error("chain out not low");
	property p_readyAtFall; $fell(chainEnableOutput) |-> configDone; endproperty
	a_readyAtFall: assert property (p_readyAtFall) else $error("low chain out, not ready");
	property p_noEarlyRead; !configDone |-> queueTake == '0; endproperty
	a_noEarlyRead: assert property (p_noEarlyRead) else $error("read before setup");
	property p_oneTake; |queueTake |-> $onehot(queueTake); endproperty
	a_oneTake: assert property (p_oneTake) else $error("two queues read");
	property p_takeValid; |queueTake |-> (queueTake & ~queueValid) == '0; endproperty
	a_takeValid: assert property (p_takeValid) else $error("empty queue read");
	property p_pollStep;
		(configDone && polledFlagMode) [*6] ##0 almostEmptyStatusEnable |=> !almostEmptyStatusEnable;
	endproperty
	a_pollStep: assert property (p_pollStep) else $error("poll did not step");
endmodule
bind queue_read_select queue_read_select_checker #(.NQ(NQ)) u_queue_read_select_checker (
	.sys_clk(sys_clk), .reset_n(reset_n), .chainEnableInput(chainEnableInput),
	.polledFlagMode(polledFlagMode), .chainEnableOutput(chainEnableOutput), .configDone(configDone),
	.queueTake(queueTake), .queueValid(queueValid), .almostEmptyStatusEnable(almostEmptyStatusEnable)
);

// >>> verif/queue_source_model.sv
// Purpose: queue storage stand-in feeding the read-select block
// Assumes: four queues of 18-bit words, always holding data
// Notes:   queue number rides on top of each word so sources can be told apart
`timescale 1ns/1ps
module queue_source_model (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  queueTake,
	output logic      [71:0] queueData,
	output logic      [3:0]  queueValid
);
	logic [15:0] count_q [4];
	assign queueValid = 4'hF;
	always_ff @(posedge sys_clk) begin
		for (int q = 0; q < 4; q++) begin
			if (!reset_n) begin
				count_q[q] <= 16'h0000;
			end else if (queueTake[q]) begin
				count_q[q] <= count_q[q] + 16'h0001;
			end
		end
	end
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			queueData[q*18+:18] = {q[1:0], count_q[q]};
		end
	end
endmodule

// >>> verif/queue_read_select_test.sv
// Purpose: self-checking bench for queue_read_select
// Assumes: 200 MHz sys_clk, a single device in the chain
// Notes:   serial clock is slow against sys_clk because the design samples it
`timescale 1ns/1ps
module queue_read_select_test;
	localparam int CFG = 16;
	logic        sys_clk = 1'b0, reset_n = 1'b0, queueSelectStrobe = 1'b0, flagDeviceStrobe = 1'b0;
	logic        readEnableN = 1'b1, serialMode = 1'b1, polledFlagMode = 1'b0, configShiftClk = 1'b0;
	logic        serialIn = 1'b0, chainEnableInput = 1'b1, chainEnableOutput, serialOut, outputValid;
	logic        configDone, almostEmptyStatusEnable;
	logic [5:0]  queueSelectBus = 6'h00;
	logic [71:0] queueData;
	logic [3:0]  queueValid, queueTake, almostEmptyStatusBus, queueAlmostEmptyN = 4'h5;
	logic [17:0] outputWordBus;
	int          fails = 0, samples_checked = 0;
	always #2.5 sys_clk = ~sys_clk;
	queue_read_select #(.CFG_BITS(CFG)) u_queue_read_select (.sys_clk, .reset_n, .queueSelectBus,
		.queueSelectStrobe, .flagDeviceStrobe, .readEnableN, .serialMode, .polledFlagMode, .configShiftClk,
		.serialIn, .chainEnableInput, .chainEnableOutput, .serialOut, .queueData, .queueValid, .queueTake,
		.queueAlmostEmptyN, .outputWordBus, .outputValid, .almostEmptyStatusBus, .almostEmptyStatusEnable,
		.configDone);
	queue_source_model u_queue_source_model (.sys_clk, .reset_n, .queueTake, .queueData, .queueValid);
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic strobe(input logic [5:0] addr, input logic flag);
		queueSelectBus <= addr;
		queueSelectStrobe <= !flag;
		flagDeviceStrobe <= flag; // one strobe at a time
		tick(1);
		queueSelectStrobe <= 1'b0;
		flagDeviceStrobe <= 1'b0;
		tick(1);
	endtask
	task automatic shift(input int n, input logic b);
		repeat (n) begin
			serialIn <= b;
			tick(4);
			configShiftClk <= 1'b1; // only clock source in the chain
			tick(4);
			configShiftClk <= 1'b0;
		end
	endtask
	// hits: words from q; stray: other words after the first hit
	task automatic watch(input logic [1:0] q, input int n, output int h, output int s, output int a, output int t);
		h = 0;
		s = 0;
		a = 0;
		t = 0;
		repeat (n) begin
			look(1);
			a += (outputValid === 1'b1);
			t += (queueTake !== 4'h0);
			if (outputValid === 1'b1 && outputWordBus[17:16] === q) h++;
			else if (outputValid === 1'b1 && h > 0) s++;
		end
		tick(1);
	endtask
	task automatic t_config;
		int k;
		shift(8, 1'b1);
		look(1);
		check(chainEnableOutput === 1'b1 && configDone === 1'b0, "chain out early");
		tick(1);
		chainEnableInput <= 1'b0; // first device driven by the bench
		shift(CFG - 1, 1'b0);
		look(8);
		check(chainEnableOutput === 1'b1, "setup done too soon");
		tick(1);
		shift(1, 1'b1);
		look(1);
		for (k = 0; k < 40 && chainEnableOutput !== 1'b0; k++) look(1);
		check(chainEnableOutput === 1'b0 && configDone === 1'b1, "setup not done");
		tick(1);
		chainEnableInput <= 1'b1;
		look(8);
		check(chainEnableOutput === 1'b1 && configDone === 1'b1, "chain out stuck low");
		tick(1);
		chainEnableInput <= 1'b0;
		look(8);
		check(chainEnableOutput === 1'b0, "chain out stuck high");
		tick(1);
	endtask
	task automatic t_read;
		int h, s, a, t;
		strobe(6'h01, 1'b0);
		watch(2'd1, 20, h, s, a, t);
		check(h == 1 && s == 0, "no fall-through word");
		watch(2'd1, 8, h, s, a, t);
		check(a == 0 && t == 0, "read while disabled");
		readEnableN <= 1'b0;
		watch(2'd1, 8, h, s, a, t);
		check(h >= 4 && s == 0, "reads missing");
	endtask
	task automatic t_switch;
		int h, s, a, t;
		queueSelectBus <= 6'h02;
		watch(2'd2, 8, h, s, a, t);
		check(h == 0, "select without strobe");
		queueSelectStrobe <= 1'b1;
		queueSelectBus <= 6'h03;
		tick(1);
		queueSelectBus <= 6'h00;
		tick(1);
		queueSelectStrobe <= 1'b0;
		watch(2'd0, 12, h, s, a, t);
		check(h > 0 && s == 0, "queue change order");
	endtask
	task automatic t_null;
		int h, s, a, t;
		strobe(6'h04, 1'b0);
		watch(2'd0, 6, h, s, a, t);
		watch(2'd0, 8, h, s, a, t);
		check(a == 0 && t == 0, "null queue read");
		readEnableN <= 1'b1;
	endtask
	task automatic t_flags;
		int k;
		int n = 0;
		strobe(6'h07, 1'b1);
		look(6);
		check(almostEmptyStatusEnable === 1'b1 && almostEmptyStatusBus === 4'h5, "device 0 status");
		tick(1);
		strobe(6'h18, 1'b1);
		look(6);
		check(almostEmptyStatusEnable === 1'b0, "device 3 status");
		tick(1);
		polledFlagMode <= 1'b1;
		tick(8);
		for (k = 0; k < 16; k++) begin
			look(1);
			n += (almostEmptyStatusEnable === 1'b1);
		end
		check(n == 2, "poll period");
	endtask
	task automatic t_default;
		tick(1);
		reset_n <= 1'b0;
		serialMode <= 1'b0;
		look(3);
		check(chainEnableOutput === 1'b1 && configDone === 1'b0 && outputValid === 1'b0 && almostEmptyStatusBus === 4'hF, "mid-run reset values");
		tick(1);
		reset_n <= 1'b1;
		look(8);
		check(chainEnableOutput === 1'b0 && configDone === 1'b1, "default setup not done");
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		tick(2);
		#1;
		check(chainEnableOutput === 1'b1 && almostEmptyStatusBus === 4'hF, "reset values");
		tick(1);
		reset_n <= 1'b1;
		t_config();
		t_read();
		t_switch();
		t_null();
		t_flags();
		t_default();
		print_verdict();
	end
	// whole run needs about 370 cycles
	initial begin
		tick(4000);
		fails++;
		print_verdict();
	end
endmodule
